// File: tam_monitor.sv
`timescale 1ns/10ps
module tam_monitor #(
    parameter int unsigned KEY_HOLD_CYC = tam_pkg::TAM_KEY_HOLD_CYC
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire tam_pkg::tam_wb_req_t  wb_req_i,
    output tam_pkg::tam_wb_rsp_t       wb_rsp_o,
    // Front-panel keys (asynchronous pins, active high)
    input  wire logic                  teach_start_key_i,
    input  wire logic                  set_key_i,
    input  wire logic                  release_key_i,
    // Feature samples and measurement errors
    input  wire tam_pkg::tam_feat_vec_t feat_i,
    input  wire logic                  feat_valid_i,
    input  wire logic                  volt_err_i,
    input  wire logic                  curr_err_i,
    input  wire logic                  freq_err_i,
    // Indicators and alarm outputs
    output tam_pkg::tam_led_t          led_o,
    output logic                       teach_led_o,
    output logic                       alarm_out1_on_o,
    output logic                       alarm_out2_on_o
);
    import tam_pkg::*;

    localparam int unsigned NF = TAM_NFEAT;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [2:0]            sync1_q, sync2_q, key_prev_q;
    logic [2:0]            sync1_d, sync2_d, key_prev_d;
    logic [TAM_HOLD_W-1:0] hold_st_q, hold_st_d, hold_set_q, hold_set_d;
    logic [TAM_AVG_LOG2-1:0] smp_cnt_q, smp_cnt_d;
    logic [NF-1:0][TAM_FW+TAM_AVG_LOG2-1:0] sum_q, sum_d;
    tam_feat_vec_t         avg_q, avg_d, norm_q, norm_d, max_q, max_d;
    tam_feat_vec_t         crit_q, crit_d, warn_q, warn_d;
    logic                  avg_ok_q, avg_ok_d;
    tam_state_t            state_q, state_d;
    logic                  tfail_q, tfail_d;
    logic [NF-1:0]         mon_q, mon_d;
    logic                  lower_q, lower_d;
    logic [6:0]            sens_q, sens_d;
    logic [NF-1:0]         crit_lat_q, crit_lat_d, warn_lat_q, warn_lat_d;
    logic                  ack_q, ack_d;
    logic [31:0]           rdat_q, rdat_d;
    tam_led_t              led_q, led_d;
    logic                  tled_q, tled_d, out1_q, out1_d, out2_q, out2_d;

    // Per-feature and shared combinational results.
    tam_feat_vec_t         thr_calc;
    logic [NF-1:0]         sel_ok, crit_hit, warn_hit;
    logic                  meas_err;
    logic                  start_fire, set_fire, rel_fire;
    logic                  bus_req, bus_wr;
    logic [31:0]           wmask;

    assign meas_err = volt_err_i | curr_err_i | freq_err_i;
    // A request is taken only while ack is low, so a master that keeps
    // cyc and stb up past the ack edge gets a second, separate transfer.
    assign bus_req  = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
    assign bus_wr   = bus_req & wb_req_i.we;
    assign wmask    = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                       {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

    // ------------------------------------------------------------
    // Per-feature threshold and judgment
    // ------------------------------------------------------------
    for (genvar i = 0; i < NF; i++) begin : g_feat
        logic [TAM_FW-1:0]   diff;
        logic [TAM_FW+6:0]   prod;
        logic [TAM_FW+6:0]   quot;
        logic [TAM_FW+3:0]   max_x10, norm_x11;
        logic                in_upper_c, in_upper_w, in_lower_c, in_lower_w;
        logic                judge_en;

        assign diff = max_q[i] - norm_q[i];
        assign prod = diff * sens_q;
        // The division floors, so a taught threshold never passes the maximum.
        assign quot = prod / 23'd100;
        assign thr_calc[i] = norm_q[i] + quot[TAM_FW-1:0];
        assign max_x10  = max_q[i] * TAM_RATIO_MAX;
        assign norm_x11 = norm_q[i] * TAM_RATIO_NORM;
        assign sel_ok[i] = TAM_CAND_MASK[i] & (max_x10 >= norm_x11);

        assign in_upper_c = feat_i[i] >= crit_q[i];
        assign in_upper_w = feat_i[i] >= warn_q[i];
        assign in_lower_c = feat_i[i] <= crit_q[i];
        assign in_lower_w = feat_i[i] <= warn_q[i];
        assign judge_en = feat_valid_i & mon_q[i] & ~meas_err;
        assign crit_hit[i] = judge_en & (lower_q ? in_lower_c : in_upper_c);
        assign warn_hit[i] = judge_en & (lower_q ? in_lower_w : in_upper_w);
    end

    // ------------------------------------------------------------
    // Key hold detection
    // ------------------------------------------------------------
    always_comb begin
        sync1_d    = {release_key_i, set_key_i, teach_start_key_i};
        sync2_d    = sync1_q;
        key_prev_d = sync2_q;
        hold_st_d  = hold_st_q;
        hold_set_d = hold_set_q;
        if (!sync2_q[0]) begin
            hold_st_d = '0;
        end else if (hold_st_q != TAM_HOLD_W'(KEY_HOLD_CYC)) begin
            hold_st_d = hold_st_q + 1'b1;
        end
        if (!sync2_q[1]) begin
            hold_set_d = '0;
        end else if (hold_set_q != TAM_HOLD_W'(KEY_HOLD_CYC)) begin
            hold_set_d = hold_set_q + 1'b1;
        end
    end

    // A hold fires once, when the count reaches the limit; the counter
    // then saturates so a key kept down does not fire again.
    assign start_fire = sync2_q[0] &
                        (hold_st_q == TAM_HOLD_W'(KEY_HOLD_CYC - 1));
    assign set_fire   = sync2_q[1] &
                        (hold_set_q == TAM_HOLD_W'(KEY_HOLD_CYC - 1));
    assign rel_fire   = sync2_q[2] & ~key_prev_q[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            key_prev_q <= '0;
            hold_st_q  <= '0;
            hold_set_q <= '0;
        end else begin
            sync1_q    <= sync1_d;
            sync2_q    <= sync2_d;
            key_prev_q <= key_prev_d;
            hold_st_q  <= hold_st_d;
            hold_set_q <= hold_set_d;
        end
    end

    // ------------------------------------------------------------
    // Averaging, teaching and thresholds
    // ------------------------------------------------------------
    always_comb begin
        smp_cnt_d = smp_cnt_q;
        sum_d     = sum_q;
        avg_d     = avg_q;
        avg_ok_d  = avg_ok_q;
        state_d   = state_q;
        tfail_d   = tfail_q;
        norm_d    = norm_q;
        max_d     = max_q;
        mon_d     = mon_q;
        crit_d    = crit_q;
        warn_d    = warn_q;
        if (feat_valid_i) begin
            smp_cnt_d = smp_cnt_q + 1'b1;
            for (int i = 0; i < NF; i++) begin
                if (smp_cnt_q == '1) begin
                    sum_d[i] = '0;
                    avg_d[i] = TAM_FW'((sum_q[i] + feat_i[i])
                                       >> TAM_AVG_LOG2);
                end else begin
                    sum_d[i] = sum_q[i] + feat_i[i];
                end
            end
            // Teaching is refused until the first full window has closed.
            if (smp_cnt_q == '1) begin
                avg_ok_d = 1'b1;
            end
        end
        // Bus writes adjust thresholds; a teaching result the same cycle
        // overrides them.
        if (bus_wr && wb_req_i.adr[5:2] < 4'(NF)) begin
            if (wb_req_i.adr[7:6] == TAM_BANK_CRIT) begin
                crit_d[wb_req_i.adr[5:2]] =
                    (crit_q[wb_req_i.adr[5:2]] & ~wmask[15:0]) |
                    (wb_req_i.dat[15:0] & wmask[15:0]);
            end
            if (wb_req_i.adr[7:6] == TAM_BANK_WARN) begin
                warn_d[wb_req_i.adr[5:2]] =
                    (warn_q[wb_req_i.adr[5:2]] & ~wmask[15:0]) |
                    (wb_req_i.dat[15:0] & wmask[15:0]);
            end
        end
        case (state_q)
            TAM_ST_IDLE: begin
                if (start_fire) begin
                    if (meas_err || !avg_ok_q) begin
                        tfail_d = 1'b1;
                    end else begin
                        tfail_d = 1'b0;
                        state_d = TAM_ST_TEACHING;
                        norm_d  = avg_q;
                        max_d   = avg_q;
                    end
                end
            end
            TAM_ST_TEACHING: begin
                if (feat_valid_i) begin
                    for (int i = 0; i < NF; i++) begin
                        if (feat_i[i] > max_q[i]) begin
                            max_d[i] = feat_i[i];
                        end
                    end
                end
                if (set_fire) begin
                    state_d = TAM_ST_IDLE;
                    max_d   = max_q;
                    mon_d   = sel_ok;
                    for (int i = 0; i < NF; i++) begin
                        if (sel_ok[i]) begin
                            crit_d[i] = thr_calc[i];
                            warn_d[i] = thr_calc[i];
                        end else begin
                            crit_d[i] = TAM_FULL_SCALE;
                            warn_d[i] = TAM_FULL_SCALE;
                        end
                    end
                end
            end
            default: begin
                state_d = TAM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smp_cnt_q <= '0;
            sum_q     <= '0;
            avg_q     <= '0;
            avg_ok_q  <= 1'b0;
            state_q   <= TAM_ST_IDLE;
            tfail_q   <= 1'b0;
            norm_q    <= '0;
            max_q     <= '0;
            mon_q     <= '0;
            crit_q    <= {NF{TAM_FULL_SCALE}};
            warn_q    <= {NF{TAM_FULL_SCALE}};
        end else begin
            smp_cnt_q <= smp_cnt_d;
            sum_q     <= sum_d;
            avg_q     <= avg_d;
            avg_ok_q  <= avg_ok_d;
            state_q   <= state_d;
            tfail_q   <= tfail_d;
            norm_q    <= norm_d;
            max_q     <= max_d;
            mon_q     <= mon_d;
            crit_q    <= crit_d;
            warn_q    <= warn_d;
        end
    end

    // ------------------------------------------------------------
    // Control, latches, bus and outputs
    // ------------------------------------------------------------
    always_comb begin
        logic cancel;
        cancel  = 1'b0;
        lower_d = lower_q;
        sens_d  = sens_q;
        ack_d   = bus_req;
        rdat_d  = rdat_q;
        if (bus_wr && wb_req_i.adr == TAM_ADR_CTRL) begin
            if (wb_req_i.sel[0]) begin
                lower_d = wb_req_i.dat[TAM_CTRL_LOWER];
                cancel  = wb_req_i.dat[TAM_CTRL_CANCEL];
            end
            if (wb_req_i.sel[1]) begin
                sens_d = (wb_req_i.dat[TAM_CTRL_SENS +: 7] > TAM_SENS_MAX) ?
                         TAM_SENS_MAX : wb_req_i.dat[TAM_CTRL_SENS +: 7];
            end
        end
        if (bus_req && !wb_req_i.we) begin
            rdat_d = '0;
            if (wb_req_i.adr == TAM_ADR_CTRL) begin
                rdat_d[TAM_CTRL_LOWER]     = lower_q;
                rdat_d[TAM_CTRL_SENS +: 7] = sens_q;
            end else if (wb_req_i.adr == TAM_ADR_STATUS) begin
                rdat_d[TAM_ST_WARN]      = |warn_lat_q;
                rdat_d[TAM_ST_CRIT]      = |crit_lat_q;
                rdat_d[TAM_ST_TEACH]     = (state_q == TAM_ST_TEACHING);
                rdat_d[TAM_ST_AVGOK]     = avg_ok_q;
                rdat_d[TAM_ST_TFAIL]     = tfail_q;
                rdat_d[TAM_ST_MERR]      = meas_err;
                rdat_d[TAM_ST_MON +: NF] = mon_q;
            end else if (wb_req_i.adr[5:2] < 4'(NF)) begin
                case (wb_req_i.adr[7:6])
                    TAM_BANK_CRIT: rdat_d[15:0] = crit_q[wb_req_i.adr[5:2]];
                    TAM_BANK_WARN: rdat_d[15:0] = warn_q[wb_req_i.adr[5:2]];
                    TAM_BANK_NORM: rdat_d[15:0] = norm_q[wb_req_i.adr[5:2]];
                    default:       rdat_d       = '0;
                endcase
            end
        end
        // key or command release, set wins
        for (int i = 0; i < NF; i++) begin
            crit_lat_d[i] = (crit_lat_q[i] & ~(cancel | rel_fire)) |
                            crit_hit[i];
            warn_lat_d[i] = (warn_lat_q[i] & ~(cancel | rel_fire)) |
                            warn_hit[i];
        end
        // Pins follow the latches one cycle later, so they all move together.
        // colour priority
        led_d.red    = |crit_lat_q;
        led_d.yellow = ~(|crit_lat_q) & (|warn_lat_q);
        led_d.green  = ~(|crit_lat_q) & ~(|warn_lat_q);
        out1_d = ~(|crit_lat_q);
        out2_d = ~(|warn_lat_q);
        tled_d = (state_q == TAM_ST_TEACHING);
    end

    // Power-on reset also clears the latches through rst_i.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lower_q    <= 1'b0;
            sens_q     <= TAM_SENS_RST;
            crit_lat_q <= '0;
            warn_lat_q <= '0;
            ack_q      <= 1'b0;
            rdat_q     <= '0;
            led_q      <= '{green: 1'b1, yellow: 1'b0, red: 1'b0};
            tled_q     <= 1'b0;
            out1_q     <= 1'b1;
            out2_q     <= 1'b1;
        end else begin
            lower_q    <= lower_d;
            sens_q     <= sens_d;
            crit_lat_q <= crit_lat_d;
            warn_lat_q <= warn_lat_d;
            ack_q      <= ack_d;
            rdat_q     <= rdat_d;
            led_q      <= led_d;
            tled_q     <= tled_d;
            out1_q     <= out1_d;
            out2_q     <= out2_d;
        end
    end

    assign wb_rsp_o.ack    = ack_q;
    assign wb_rsp_o.dat    = rdat_q;
    assign led_o           = led_q;
    assign teach_led_o     = tled_q;
    assign alarm_out1_on_o = out1_q;
    assign alarm_out2_on_o = out2_q;

endmodule

// File: tam_monitor_assertions.sv
`timescale 1ns/10ps
module tam_monitor_checker
    import tam_pkg::*;
#(
    parameter int unsigned KEY_HOLD_CYC = 20
) (
    // Clock and reset
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    // Watched inputs
    input wire tam_pkg::tam_wb_req_t wb_req_i,
    input wire logic                 teach_start_key_i,
    input wire logic                 release_key_i,
    input wire logic                 feat_valid_i,
    input wire logic                 volt_err_i,
    input wire logic                 curr_err_i,
    input wire logic                 freq_err_i,
    // Watched outputs
    input wire tam_pkg::tam_led_t    led_o,
    input wire logic                 teach_led_o,
    input wire logic                 alarm_out1_on_o,
    input wire logic                 alarm_out2_on_o
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // The last run length is kept because the key may already be up
    // when the synchronised hold count fires.
    logic [31:0] run_q, run_d, last_q, last_d;
    logic [3:0]  quiet_q, quiet_d;
    logic        merr;
    assign merr = volt_err_i || curr_err_i || freq_err_i;
    always_comb begin
        run_d   = teach_start_key_i ? run_q + 32'h1 : 32'h0;
        last_d  = (!teach_start_key_i && run_q != 32'h0) ? run_q : last_q;
        quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
        if (release_key_i || (wb_req_i.cyc && wb_req_i.we)) begin
            quiet_d = 4'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q   <= 32'h0;
            last_q  <= 32'h0;
            quiet_q <= 4'h0;
        end else begin
            run_q   <= run_d;
            last_q  <= last_d;
            quiet_q <= quiet_d;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_led_onehot: assert property ($onehot(led_o))
        else $error("indicator not one-hot");
    a_red_out1: assert property (led_o.red == !alarm_out1_on_o)
        else $error("red and output 1 disagree");
    a_yellow_out2: assert property (
        led_o.yellow == (alarm_out1_on_o && !alarm_out2_on_o))
        else $error("yellow and output 2 disagree");
    a_green_quiet: assert property (
        led_o.green == (alarm_out1_on_o && alarm_out2_on_o))
        else $error("green shown with an alarm");
    a_err_blocks: assert property (
        (merr && feat_valid_i && alarm_out1_on_o && alarm_out2_on_o
         && !$past(feat_valid_i)) |=> ##1
        (alarm_out1_on_o && alarm_out2_on_o))
        else $error("alarm raised during measurement error");
    a_crit_held: assert property (
        (quiet_q >= 4'h6 && !alarm_out1_on_o) |=> !alarm_out1_on_o)
        else $error("critical latch dropped");
    a_warn_held: assert property (
        (quiet_q >= 4'h6 && !alarm_out2_on_o) |=> !alarm_out2_on_o)
        else $error("warning latch dropped");
    a_reset_vals: assert property (disable iff (1'b0) rst_i |=>
        (led_o.green && !teach_led_o && alarm_out1_on_o && alarm_out2_on_o))
        else $error("outputs not at reset values");
    a_hold_first: assert property ($rose(teach_led_o) |->
        (run_q >= KEY_HOLD_CYC || last_q >= KEY_HOLD_CYC))
        else $error("teaching began without a full key hold");
endmodule

bind tam_monitor tam_monitor_checker #(.KEY_HOLD_CYC(KEY_HOLD_CYC)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .teach_start_key_i(teach_start_key_i), .release_key_i(release_key_i),
    .feat_valid_i(feat_valid_i), .volt_err_i(volt_err_i),
    .curr_err_i(curr_err_i), .freq_err_i(freq_err_i), .led_o(led_o),
    .teach_led_o(teach_led_o), .alarm_out1_on_o(alarm_out1_on_o),
    .alarm_out2_on_o(alarm_out2_on_o));

// File: tam_panel_model.sv
`timescale 1ns/10ps
module tam_panel_model (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Bench commands
    input  wire tam_pkg::tam_feat_vec_t level_i,
    input  wire logic [2:0]             press_i,
    // Sample stream and key pins
    output tam_pkg::tam_feat_vec_t      feat_o,
    output logic                        feat_valid_o,
    output logic [2:0]                  key_o
);
    import tam_pkg::*;
    logic [1:0] tick_q;
    // Between strobes the sample bus carries junk, so a design that
    // reads it unqualified sees wrong values rather than stale ones.
    always_ff @(posedge clk_i) begin
        tick_q       <= rst_i ? 2'h0 : tick_q + 2'h1;
        feat_valid_o <= !rst_i && tick_q == 2'h3;
        feat_o       <= (tick_q == 2'h3) ? level_i : ~level_i;
        key_o        <= press_i;
    end
endmodule

// File: tam_pkg.sv
// Operation
// - Average each feature over every calculation cycle.
// - Start key held 3 s begins teaching.
// - Measurement error at start fails teaching.
// - Track per-feature maximum throughout teaching.
// - Set key held 3 s ends teaching.
// - Skip feature whose maximum is below 1.1x normal.
// - Only five candidate features may be monitored.
// - Unselected features get full-scale threshold 32761.
// - Thresholds use sensitivity setting, default 80%.
// - Teaching writes equal critical and warning thresholds.
// - Judge only monitored features, critical and warning.
// - Alarm type upper or lower, host writable.
// - Upper mode: on when feature reaches threshold.
// - Lower mode: on when feature at or below.
// - Judgment results stay latched until released.
// - Key, command or reset clears latched alarms.
// - Critical opens output 1, warning output 2.
// - Alarms set warning and critical status bits.
// - Measurement error suppresses alarm judgment.
package tam_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int unsigned TAM_NFEAT        = 9;
    localparam int unsigned TAM_FW           = 16;
    localparam int unsigned TAM_AVG_LOG2     = 4;
    localparam int unsigned TAM_CLK_HZ       = 40_000_000;
    localparam int unsigned TAM_KEY_HOLD_S   = 3;
    localparam int unsigned TAM_KEY_HOLD_CYC = TAM_KEY_HOLD_S * TAM_CLK_HZ;
    localparam int unsigned TAM_HOLD_W       = 27;

    // ------------------------------------------------------------
    // Feature selection and threshold constants
    // ------------------------------------------------------------
    localparam logic [8:0]  TAM_CAND_MASK  = 9'h01F;
    localparam logic [15:0] TAM_FULL_SCALE = 16'h7FF9;
    localparam logic [6:0]  TAM_SENS_RST   = 7'h50;
    localparam logic [6:0]  TAM_SENS_MAX   = 7'h64;
    localparam logic [3:0]  TAM_RATIO_MAX  = 4'hA;
    localparam logic [3:0]  TAM_RATIO_NORM = 4'hB;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TAM_ADR_CTRL   = 8'h00;
    localparam logic [7:0] TAM_ADR_STATUS = 8'h04;
    localparam logic [1:0] TAM_BANK_CRIT  = 2'h1;
    localparam logic [1:0] TAM_BANK_WARN  = 2'h2;
    localparam logic [1:0] TAM_BANK_NORM  = 2'h3;

    // Control register fields.
    localparam int unsigned TAM_CTRL_LOWER  = 0;
    localparam int unsigned TAM_CTRL_CANCEL = 1;
    localparam int unsigned TAM_CTRL_SENS   = 8;

    // Status register fields.
    localparam int unsigned TAM_ST_WARN   = 0;
    localparam int unsigned TAM_ST_CRIT   = 1;
    localparam int unsigned TAM_ST_TEACH  = 2;
    localparam int unsigned TAM_ST_AVGOK  = 3;
    localparam int unsigned TAM_ST_TFAIL  = 4;
    localparam int unsigned TAM_ST_MERR   = 5;
    localparam int unsigned TAM_ST_MON    = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [TAM_NFEAT-1:0][TAM_FW-1:0] tam_feat_vec_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tam_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } tam_wb_rsp_t;

    typedef struct packed {
        logic green;
        logic yellow;
        logic red;
    } tam_led_t;

    typedef enum logic {
        TAM_ST_IDLE,
        TAM_ST_TEACHING
    } tam_state_t;

endpackage

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
    import tam_pkg::*;
    localparam int unsigned HOLD = 20;
    logic          clk_i, rst_i, fv, tled, o1, o2, ve, ce, fe;
    logic [2:0]    press, keys;
    tam_wb_req_t   wb_req;
    tam_wb_rsp_t   wb_rsp;
    tam_feat_vec_t level, feat;
    tam_led_t      led;
    int            error_cnt = 0;
    int            n_checks = 0;
    logic [15:0]   thr [9] = '{16'h0708, 16'h7FF9, 16'h0438, 16'h7FF9,
        16'h7FF9, 16'h7FF9, 16'h7FF9, 16'h7FF9, 16'h7FF9};

    tam_monitor #(.KEY_HOLD_CYC(HOLD)) i_tam_monitor (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
        .wb_rsp_o(wb_rsp), .teach_start_key_i(keys[0]),
        .set_key_i(keys[1]), .release_key_i(keys[2]), .feat_i(feat),
        .feat_valid_i(fv), .volt_err_i(ve), .curr_err_i(ce),
        .freq_err_i(fe), .led_o(led), .teach_led_o(tled),
        .alarm_out1_on_o(o1), .alarm_out2_on_o(o2));
    tam_panel_model i_tam_panel_model (
        .clk_i(clk_i), .rst_i(rst_i), .level_i(level), .press_i(press),
        .feat_o(feat), .feat_valid_o(fv), .key_o(keys));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hF, dat:wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        rd = wb_rsp.dat;
        chk({31'h0, wb_rsp.ack}, 32'h1);
        wb_req <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] d;
        wb(1'b0, a, 32'h0, d);
        chk(d & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask
    task automatic pins(input logic [5:0] e);
        chk({26'h0, led, tled, o1, o2}, {26'h0, e});
    endtask
    task automatic push(input int k);
        press[k] <= 1'b1;
        repeat (HOLD + 10) @(posedge clk_i);
        press[k] <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic settle;
        repeat (16) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        wb_req = '0;
        level = {9{16'h03E8}};
        press = 3'h0;
        {fe, ce, ve} = 3'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        pins(6'b100_0_11);
        rd(TAM_ADR_CTRL, 32'h0000_5000);
        rd(TAM_ADR_STATUS, 32'h0);
        rd(8'h40, 32'h0000_7FF9);
        rd(8'h3C, 32'h0);
        push(0);
        rd(TAM_ADR_STATUS, 32'h10, 32'h14);
        repeat (40) @(posedge clk_i);
        rd(TAM_ADR_STATUS, 32'h08, 32'h08);
        ve <= 1'b1;
        push(0);
        rd(TAM_ADR_STATUS, 32'h30, 32'h34);
        pins(6'b100_0_11);
        ve <= 1'b0;
        push(0);
        pins(6'b100_1_11);
        rd(TAM_ADR_STATUS, 32'h04, 32'h04);
        rd(8'hC0, 32'h0000_03E8);
        level[0] <= 16'h07D0;
        level[1] <= 16'h041A;
        level[2] <= 16'h044C;
        level[5] <= 16'h0BB8;
        repeat (80) @(posedge clk_i);
        level <= {9{16'h03E8}};
        settle();
        push(1);
        pins(6'b100_0_11);
        rd(TAM_ADR_STATUS, 32'h0005_0000, 32'h01FF_0004);
        for (int i = 0; i < 9; i++) begin
            rd(8'h40 + 8'(4 * i), {16'h0, thr[i]});
            rd(8'h80 + 8'(4 * i), {16'h0, thr[i]});
        end
        level[5] <= 16'hFFFF;
        settle();
        pins(6'b100_0_11);
        wr(8'h80, 32'h0000_05DC);
        level[0] <= 16'h0640;
        settle();
        pins(6'b010_0_10);
        rd(TAM_ADR_STATUS, 32'h01, 32'h03);
        level[0] <= 16'h03E8;
        settle();
        pins(6'b010_0_10);
        level[0] <= 16'h0708;
        settle();
        pins(6'b001_0_00);
        rd(TAM_ADR_STATUS, 32'h03, 32'h03);
        level[0] <= 16'h03E8;
        settle();
        wr(TAM_ADR_CTRL, 32'h0000_5002);
        settle();
        pins(6'b100_0_11);
        level[0] <= 16'h0708;
        settle();
        level[0] <= 16'h03E8;
        push(2);
        pins(6'b100_0_11);
        for (int e = 0; e < 3; e++) begin
            {fe, ce, ve} <= 3'(1 << e);
            level[0] <= 16'h0708;
            settle();
            pins(6'b100_0_11);
            level[0] <= 16'h03E8;
            settle();
        end
        // Levels move while an error still masks judgment, so no hit is
        // latched in upper mode before the alarm type changes.
        level[0] <= 16'h0709;
        level[2] <= 16'h07D0;
        settle();
        pins(6'b100_0_11);
        wr(TAM_ADR_CTRL, 32'h0000_5001);
        rd(TAM_ADR_CTRL, 32'h0000_5001);
        {fe, ce, ve} <= 3'h0;
        settle();
        pins(6'b100_0_11);
        level[0] <= 16'h0708;
        settle();
        pins(6'b001_0_01);
        rd(TAM_ADR_STATUS, 32'h02, 32'h03);
        wr(TAM_ADR_CTRL, 32'h0000_7F00);
        rd(TAM_ADR_CTRL, 32'h0000_6400);
        test_done();
    end
    initial begin
        repeat (10000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
endmodule
